// [common/sipo_pkg.sv]
// Shared constants for the serial-in, parallel-out shift and storage register block.
// Assumes a single 100 MHz system clock with synchronous active-high reset.
package sipo_pkg;

    localparam int          STAGE_COUNT   = 8;
    localparam logic [7:0]  CLEAR_VALUE   = 8'h00;
    localparam int          SYNC_DEPTH    = 2;
    localparam logic [1:0]  EDGE_RISE     = 2'h1;
    localparam logic [1:0]  EDGE_FALL     = 2'h2;
    localparam logic [1:0]  EDGE_NONE     = 2'h0;

endpackage : sipo_pkg

// [rtl/pin_sync.sv]
// Two-flop synchroniser for a level arriving from a pin.
// Assumes the pin is asynchronous to clk; only the second flop is read.
`timescale 1ns/1ps
module pin_sync
    import sipo_pkg::*;
#(
    parameter logic RESET_LEVEL = 1'b0
)
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin_in,
    output logic      level_out
);

    typedef struct packed
    {
        logic meta;
        logic stable;
    } sync_s;

    sync_s state_reg;
    sync_s state_next;

    always_comb
    begin
        state_next        = state_reg;
        state_next.meta   = pin_in;
        state_next.stable = state_reg.meta;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg <= '{meta: RESET_LEVEL, stable: RESET_LEVEL};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign level_out = state_reg.stable;

endmodule : pin_sync

// [rtl/edge_detect.sv]
// Classifies edges of an already synchronised level into rise and fall pulses.
// Assumes the input is on the clk domain.
`timescale 1ns/1ps
module edge_detect
    import sipo_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       level_in,
    output logic [1:0]      edge_kind
);

    typedef struct packed
    {
        logic last;
    } edge_s;

    edge_s state_reg;
    edge_s state_next;

    always_comb
    begin
        state_next      = state_reg;
        state_next.last = level_in;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg <= '{last: 1'b0};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    always_comb
    begin
        if (level_in && !state_reg.last)
        begin
            edge_kind = EDGE_RISE;
        end
        else if (!level_in && state_reg.last)
        begin
            edge_kind = EDGE_FALL;
        end
        else
        begin
            edge_kind = EDGE_NONE;
        end
    end

endmodule : edge_detect

// [rtl/sipo_shift_storage_register.sv]
// Serial-in, parallel-out shift register feeding a parallel storage register.
// Assumes all pins are asynchronous to clk and change slower than clk.
`timescale 1ns/1ps
module sipo_shift_storage_register
    import sipo_pkg::*;
#(
    parameter int WIDTH = STAGE_COUNT
)
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             shift_data_in,
    input  wire logic             shift_clock,
    input  wire logic             shift_clear_n,
    input  wire logic             storage_clock,
    input  wire logic             storage_clear_n,
    output logic [WIDTH-1:0]      parallel_out,
    output logic                  cascade_out
);

    logic             data_sync;
    logic             shift_clk_sync;
    logic             storage_clk_sync;
    logic             shift_clr_n_sync;
    logic             storage_clr_n_sync;
    logic [1:0]       shift_edge;
    logic [1:0]       storage_edge;

    // Each pin has its own synchroniser; the clears come in high (inactive).
    pin_sync #(.RESET_LEVEL(1'b0)) u_sync_data
    (
        .clk       (clk),
        .rst       (rst),
        .pin_in    (shift_data_in),
        .level_out (data_sync)
    );

    pin_sync #(.RESET_LEVEL(1'b0)) u_sync_shift_clk
    (
        .clk       (clk),
        .rst       (rst),
        .pin_in    (shift_clock),
        .level_out (shift_clk_sync)
    );

    pin_sync #(.RESET_LEVEL(1'b0)) u_sync_storage_clk
    (
        .clk       (clk),
        .rst       (rst),
        .pin_in    (storage_clock),
        .level_out (storage_clk_sync)
    );

    pin_sync #(.RESET_LEVEL(1'b1)) u_sync_shift_clr
    (
        .clk       (clk),
        .rst       (rst),
        .pin_in    (shift_clear_n),
        .level_out (shift_clr_n_sync)
    );

    pin_sync #(.RESET_LEVEL(1'b1)) u_sync_storage_clr
    (
        .clk       (clk),
        .rst       (rst),
        .pin_in    (storage_clear_n),
        .level_out (storage_clr_n_sync)
    );

    edge_detect u_shift_edge
    (
        .clk       (clk),
        .rst       (rst),
        .level_in  (shift_clk_sync),
        .edge_kind (shift_edge)
    );

    edge_detect u_storage_edge
    (
        .clk       (clk),
        .rst       (rst),
        .level_in  (storage_clk_sync),
        .edge_kind (storage_edge)
    );

    typedef struct packed
    {
        logic [WIDTH-1:0] shift_stages;
        logic [WIDTH-1:0] storage_bits;
        logic [WIDTH-1:0] parallel_q;
        logic             cascade_q;
    } sipo_s;

    sipo_s state_reg;
    sipo_s state_next;

    // Data is sampled in the same cycle as the edge, so it need only be present by the
    // same clk sample as the clock pin edge, since both pin synchronisers have equal delay.
    always_comb
    begin
        state_next = state_reg;
        if (!shift_clr_n_sync)
        begin
            state_next.shift_stages = CLEAR_VALUE[WIDTH-1:0];
        end
        else if (shift_edge == EDGE_RISE)
        begin
            state_next.shift_stages = {state_reg.shift_stages[WIDTH-2:0],
                                       data_sync};
        end
        if (!storage_clr_n_sync)
        begin
            state_next.storage_bits = CLEAR_VALUE[WIDTH-1:0];
        end
        else if (storage_edge == EDGE_RISE)
        begin
            // Takes the shift contents from before a simultaneous shift edge.
            state_next.storage_bits = state_reg.shift_stages;
        end
        state_next.parallel_q = state_next.storage_bits;
        state_next.cascade_q  = state_next.shift_stages[WIDTH-1];
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign parallel_out = state_reg.parallel_q;
    assign cascade_out  = state_reg.cascade_q;

endmodule : sipo_shift_storage_register

// [testbench/sipo_checker.sv]
// Port checker for the shift and storage register block.
// Assumes every pin holds each level for at least three clk cycles.
`timescale 1ns/1ps
module sipo_checker
#(
    parameter int WIDTH = 8
)
(
    input wire logic             clk,
    input wire logic             rst,
    input wire logic             shift_data_in,
    input wire logic             shift_clock,
    input wire logic             shift_clear_n,
    input wire logic             storage_clock,
    input wire logic             storage_clear_n,
    input wire logic [WIDTH-1:0] parallel_out,
    input wire logic             cascade_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence sh_clr; !shift_clear_n [*3]; endsequence
    sequence st_clr; !storage_clear_n [*3]; endsequence
    sequence sh_idle; (shift_clear_n && !$rose(shift_clock)) [*5]; endsequence
    sequence st_idle; (storage_clear_n && !$rose(storage_clock)) [*5]; endsequence
    // A pin event shows at the outputs three clk edges later, so three samples of one
    // clear alone, with the other register idle, must leave the other output still.
    sequence sh_only;
        (!shift_clear_n && storage_clear_n && !$rose(storage_clock)) [*3];
    endsequence
    sequence st_only;
        (!storage_clear_n && shift_clear_n && !$rose(shift_clock)) [*3];
    endsequence
    a_reset_out: assert property (disable iff (1'b0)
        rst |=> parallel_out == '0 && !cascade_out)
        else $error("outputs not zero after reset");
    a_shift_clr: assert property (sh_clr |=> !cascade_out)
        else $error("cascade not cleared");
    a_store_clr: assert property (st_clr |=> parallel_out == '0)
        else $error("storage not cleared");
    a_shift_edge: assert property (sh_idle |-> $stable(cascade_out))
        else $error("cascade moved without rise");
    a_store_edge: assert property (st_idle |-> $stable(parallel_out))
        else $error("storage moved without rise");
    a_clr_split: assert property (sh_only |=> $stable(parallel_out))
        else $error("shift clear reached storage");
    a_clr_apart: assert property (st_only |=> $stable(cascade_out))
        else $error("storage clear reached cascade");
    a_store_held: assert property (!storage_clear_n [*5] |-> $stable(parallel_out))
        else $error("storage moved under clear");
endmodule : sipo_checker

bind sipo_shift_storage_register sipo_checker #(.WIDTH(WIDTH)) chk_u (.clk(clk), .rst(rst),
    .shift_data_in(shift_data_in), .shift_clock(shift_clock), .shift_clear_n(shift_clear_n),
    .storage_clock(storage_clock), .storage_clear_n(storage_clear_n),
    .parallel_out(parallel_out), .cascade_out(cascade_out));

// [testbench/pin_driver.sv]
// Controller model that works the five input pins of the register block.
// Assumes clk is the bench clock; each pin level is held four clk cycles.
`timescale 1ns/1ps
module pin_driver
(
    input  wire logic clk,
    output logic      shift_data_in,
    output logic      shift_clock,
    output logic      shift_clear_n,
    output logic      storage_clock,
    output logic      storage_clear_n
);
    initial {shift_data_in, shift_clock, shift_clear_n, storage_clock, storage_clear_n} = 5'h05;
    task put(input logic [4:0] v);
        @(posedge clk);
        {shift_data_in, shift_clock, shift_clear_n, storage_clock, storage_clear_n} <= v;
        repeat (3) @(posedge clk);
    endtask : put
    // Data is inverted once its hold has run out, so a falling edge that acts is seen.
    task pulse(input logic d, input logic s, input logic r, input logic [1:0] c);
        put({d, 1'b0, c[1], 1'b0, c[0]});
        put({d, s, c[1], r, c[0]});
        put({~d, 1'b0, c[1], 1'b0, c[0]});
    endtask : pulse
endmodule : pin_driver

// [testbench/sipo_shift_storage_register_tb.sv]
// Self-checking bench for the shift and storage register block.
// Assumes the pin driver and the bound checker are compiled before it.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
    $display("mismatch %0t output differs from model", $time); end end
module sipo_shift_storage_register_tb;
    import sipo_pkg::*;
    logic                   clk = 1'b0;
    logic                   rst = 1'b1;
    logic                   sd, sck, sclr_n, rck, storage_clear_n_n, cout;
    logic [STAGE_COUNT-1:0] pout;
    int                     errors = 0;
    int                     cmp_count = 0;
    int                     sh_m = 0;
    int                     st_m = 0;
    initial forever #5 clk = ~clk;
    pin_driver drv_u (.clk(clk), .shift_data_in(sd), .shift_clock(sck), .shift_clear_n(sclr_n),
        .storage_clock(rck), .storage_clear_n(storage_clear_n_n));
    sipo_shift_storage_register dut_u (.clk(clk), .rst(rst), .shift_data_in(sd),
        .shift_clock(sck), .shift_clear_n(sclr_n), .storage_clock(rck),
        .storage_clear_n(storage_clear_n_n), .parallel_out(pout), .cascade_out(cout));
    task complete_run;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run
    initial
    begin
        #100us;
        errors++;
        complete_run();
    end
    initial
    begin
        logic       d, s, r;
        logic [1:0] c;
        void'($urandom(70301));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (400)
        begin
            d = 1'($urandom);
            s = 1'($urandom);
            r = ($urandom % 2) ? s : 1'($urandom);
            c = ($urandom % 6) ? 2'h3 : 2'($urandom);
            drv_u.pulse(d, s, r, c);
            if (!c[1])
                sh_m = 0;
            if (!c[0])
                st_m = 0;
            else if (r)
                st_m = sh_m;
            if (c[1] && s)
                sh_m = ((sh_m << 1) | d) & 8'hFF;
            @(negedge clk);
            `CHK(pout, STAGE_COUNT'(st_m))
            `CHK(cout, 1'(sh_m >> 7))
        end
        complete_run();
    end
endmodule : sipo_shift_storage_register_tb
